// File: core/clear_channel_assessment.sv
// Clear channel assessment: modes, requests, flags and timing
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Energy mode: busy on energy above threshold
// - Carrier mode: busy only on compliant carrier
// - Mode 0 ORs, mode 3 ANDs both
// - Request bit starts measurement in receive states
// - Listening: eight symbols, result at 140 us
// - Completion event on manual assessment end
// - Threshold is floor plus twice field
// - New request clears done and idle flags
// - Done set at end; idle only if clear
// - Carrier detector flags compliant signals as busy
// - Request outside receive still completes, no measurement
// - Busy-receive during energy run: early, second event
// - Busy-receive timing per mode and request moment
// - One automated energy run per frame header
// - Preamble detect disable keeps receiver listening
// - Done flag is status bit 7
// - Mode and request live in control register
// - Sensitivity floor is minus ninety-one dBm
// - Request bit clears itself
// - Threshold field is bits four to zero
// - Idle flag is status bit 6
module clear_channel_assessment
  import cca_pkg::*;
#(
  parameter int MEAS_CYCLES   = MEAS_CYC,
  parameter int RESULT_CYCLES = RESULT_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register access port
  input  wire logic [5:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Receiver state and measurements, same clock
  input  wire logic       basic_mode,
  input  wire logic       rx_listen,
  input  wire logic       rx_busy,
  input  wire logic       shr_detected,
  input  wire logic [4:0] rssi_value,
  input  wire logic       carrier_detect,
  input  wire logic [4:0] trx_state,
  // Events and controls to the radio
  output logic            measure_done_event,
  output logic            preamble_detect_disable
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Registers and request decode
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] thres_r;
  logic [7:0] sync_r;
  logic [7:0] rdata_r;
  logic       done_r;
  logic       idle_r;
  logic       irq_r;
  mode_type   mode_r;
  state_type  st_r;
  logic       e_seen_r;
  logic       c_seen_r;
  logic       auto_e_r;
  logic       frame_auto_r;
  logic       start_r;
  logic       auto_start_r;

  logic       req;
  mode_type   req_mode;
  logic       can_meas;

  assign req      = reg_wr_en && (reg_addr == CTRL_ADDR)
                 && reg_wdata[REQ_BIT];
  assign req_mode = mode_type'(reg_wdata[MODE_HI:MODE_LO]);
  // Extended mode counts as outside the basic receive states
  assign can_meas = basic_mode && (rx_listen || rx_busy);

  // Request bit is never stored, so it reads back as zero
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_r  <= CTRL_RST;
      thres_r <= THRES_RST;
      sync_r  <= SYNC_RST;
    end else if (reg_wr_en) begin
      case (reg_addr)
        CTRL_ADDR:  ctrl_r  <= {1'b0, reg_wdata[6:0]};
        THRES_ADDR: thres_r <= reg_wdata;
        SYNC_ADDR:  sync_r  <= reg_wdata;
        default:    ctrl_r  <= ctrl_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        STATUS_ADDR: rdata_r <= {done_r, idle_r, 1'b0,
                                 trx_state};
        CTRL_ADDR:   rdata_r <= ctrl_r;
        THRES_ADDR:  rdata_r <= thres_r;
        SYNC_ADDR:   rdata_r <= sync_r;
        default:     rdata_r <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Energy comparison
  // ----------------------------------------------------------------
  logic [6:0]        rssi3;
  logic signed [9:0] pwr_dbm;
  logic signed [9:0] thr_dbm;
  logic              energy_now;

  assign rssi3   = 7'(rssi_value) * 7'h03;
  assign pwr_dbm = SENS_FLOOR_DBM + $signed({3'b000, rssi3})
                 - 10'sd3;
  assign thr_dbm = SENS_FLOOR_DBM
                 + $signed({4'h0, thres_r[THR_HI:0], 1'b0});
  assign energy_now = (rssi_value != 5'h00) && (pwr_dbm > thr_dbm);

  function automatic logic chan_busy(mode_type m, logic e, logic c);
    case (m)
      MODE_OR:      chan_busy = e | c;
      MODE_ENERGY:  chan_busy = e;
      MODE_CARRIER: chan_busy = c;
      MODE_AND:     chan_busy = e & c;
      default:      chan_busy = e | c;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  cca_tmr_if man_t ();
  cca_tmr_if auto_t ();

  assign man_t.start  = start_r;
  assign auto_t.start = auto_start_r;

  cca_timer #(
    .CNT_W    (16),
    .MEAS_LEN (MEAS_CYCLES),
    .RES_LEN  (RESULT_CYCLES)
  ) u_man_tmr (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .tp    (man_t.tmr)
  );

  cca_timer #(
    .CNT_W    (16),
    .MEAS_LEN (MEAS_CYCLES),
    .RES_LEN  (MEAS_CYCLES)
  ) u_auto_tmr (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .tp    (auto_t.tmr)
  );

  // ----------------------------------------------------------------
  // Automated energy run, once per frame
  // ----------------------------------------------------------------
  logic auto_go;
  assign auto_go = shr_detected && rx_busy && !frame_auto_r
                && !sync_r[PDT_BIT];

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      frame_auto_r <= 1'b0;
      auto_start_r <= 1'b0;
    end else begin
      auto_start_r <= auto_go;
      if (!rx_busy) begin
        frame_auto_r <= 1'b0;
      end else if (auto_go) begin
        frame_auto_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      auto_e_r <= 1'b0;
    end else if (auto_start_r) begin
      auto_e_r <= energy_now;
    end else if (auto_t.running) begin
      auto_e_r <= auto_e_r | energy_now;
    end
  end

  // ----------------------------------------------------------------
  // Request sequencing
  // ----------------------------------------------------------------
  logic auto_busy;
  logic imm_fin;
  logic early_ev;
  logic lst_fin;
  logic aut_fin;
  logic out_fin;
  logic imm_e;

  // Auto run counts as busy from its trigger until it ends
  assign auto_busy = auto_start_r || (auto_t.running && !auto_t.meas_end);
  assign out_fin  = req && !can_meas;
  assign imm_fin  = req && can_meas && !rx_listen
                 && ((req_mode == MODE_CARRIER) || !auto_busy);
  assign early_ev = req && can_meas && !rx_listen
                 && (req_mode != MODE_CARRIER) && auto_busy;
  assign lst_fin  = (st_r == ST_PROC) && man_t.res_end && !req;
  assign aut_fin  = (st_r == ST_WAIT_AUTO) && !req
                 && (auto_t.meas_end || !auto_t.running);
  assign imm_e    = frame_auto_r ? auto_e_r : energy_now;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r    <= ST_IDLE;
      mode_r  <= MODE_ENERGY;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (req) begin
        mode_r <= req_mode;
        if (can_meas && rx_listen) begin
          st_r    <= ST_MEAS;
          start_r <= 1'b1;
        end else if (early_ev) begin
          st_r <= ST_WAIT_AUTO;
        end else begin
          st_r <= ST_IDLE;
        end
      end else begin
        case (st_r)
          ST_IDLE:      st_r <= ST_IDLE;
          ST_MEAS:      if (man_t.meas_end) st_r <= ST_PROC;
          ST_PROC:      if (man_t.res_end) st_r <= ST_IDLE;
          ST_WAIT_AUTO: if (aut_fin) st_r <= ST_IDLE;
          default:      st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Evidence gathered over the measurement window
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      e_seen_r <= 1'b0;
      c_seen_r <= 1'b0;
    end else if (req) begin
      e_seen_r <= 1'b0;
      c_seen_r <= carrier_detect;
    end else if (st_r == ST_MEAS || st_r == ST_WAIT_AUTO) begin
      e_seen_r <= e_seen_r | energy_now;
      c_seen_r <= c_seen_r | carrier_detect;
    end
  end

  // ----------------------------------------------------------------
  // Status flags and completion event
  // ----------------------------------------------------------------
  // A new request outranks listening and auto-run completion, so a result due in that cycle is dropped
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      done_r <= 1'b0;
      idle_r <= 1'b0;
    end else if (out_fin) begin
      done_r <= 1'b1;
      idle_r <= 1'b0;
    end else if (imm_fin) begin
      done_r <= 1'b1;
      idle_r <= !chan_busy(req_mode, imm_e, carrier_detect);
    end else if (req) begin
      done_r <= 1'b0;
      idle_r <= 1'b0;
    end else if (lst_fin) begin
      done_r <= 1'b1;
      idle_r <= !chan_busy(mode_r, e_seen_r, c_seen_r);
    end else if (aut_fin) begin
      done_r <= 1'b1;
      idle_r <= !chan_busy(mode_r, auto_e_r | energy_now, c_seen_r);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= out_fin || imm_fin || early_ev
            || lst_fin || aut_fin;
    end
  end

  assign reg_rdata               = rdata_r;
  assign measure_done_event      = irq_r;
  assign preamble_detect_disable = sync_r[PDT_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] elapsed_r;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      elapsed_r <= 16'h0000;
    end else if (req) begin
      elapsed_r <= 16'h0000;
    end else if (st_r != ST_IDLE) begin
      elapsed_r <= elapsed_r + 16'h0001;
    end
  end

  AST_REQ_CLEARS: assert property (@(posedge clk)
    disable iff (!rst_sync_n)
    req && can_meas && rx_listen |=> !done_r && !idle_r)
    else $error("request did not clear flags");
  AST_OUTSIDE_DONE: assert property (@(posedge clk)
    disable iff (!rst_sync_n)
    req && !can_meas |=> done_r && irq_r && !idle_r)
    else $error("request outside receive did not complete");
  AST_LISTEN_TIME: assert property (@(posedge clk)
    disable iff (!rst_sync_n)
    lst_fin |-> elapsed_r >= 16'(RESULT_CYCLES))
    else $error("listening result came too early");
  AST_CARRIER_MODE: assert property (@(posedge clk)
    disable iff (!rst_sync_n)
    lst_fin && mode_r == MODE_CARRIER |=> idle_r == !$past(c_seen_r))
    else $error("carrier mode result wrong");
  AST_AND_MODE: assert property (@(posedge clk)
    disable iff (!rst_sync_n)
    lst_fin && mode_r == MODE_AND
    |=> idle_r == !($past(e_seen_r) && $past(c_seen_r)))
    else $error("and mode result wrong");
  AST_ENERGY_SEEN: assert property (@(posedge clk)
    disable iff (!rst_sync_n)
    st_r == ST_MEAS && energy_now && !req |=> e_seen_r)
    else $error("energy sample not recorded");
  AST_EVENT_DONE: assert property (@(posedge clk)
    disable iff (!rst_sync_n)
    lst_fin ##1 1'b1 |-> irq_r && done_r)
    else $error("completion event without done flag");
  AST_SELF_CLEAR: assert property (@(posedge clk)
    disable iff (!rst_sync_n)
    reg_rd_en && reg_addr == CTRL_ADDR |=> !reg_rdata[REQ_BIT])
    else $error("request bit reads back as one");
  AST_AUTO_ONCE: assert property (@(posedge clk)
    disable iff (!rst_sync_n)
    auto_start_r |-> frame_auto_r && !$past(frame_auto_r))
    else $error("second automated run in one frame");
  AST_EARLY_WAIT: assert property (@(posedge clk)
    disable iff (!rst_sync_n)
    early_ev |=> irq_r && !done_r && st_r == ST_WAIT_AUTO)
    else $error("early event handling wrong");

endmodule
`default_nettype wire

// File: core/cca_pkg.sv
// Constants and types shared by the clear channel assessment block
package cca_pkg;

  // ----------------------------------------------------------------
  // Register offsets and field positions
  // ----------------------------------------------------------------
  localparam logic [5:0] STATUS_ADDR = 6'h01;
  localparam logic [5:0] CTRL_ADDR   = 6'h08;
  localparam logic [5:0] THRES_ADDR  = 6'h09;
  localparam logic [5:0] SYNC_ADDR   = 6'h15;

  localparam int DONE_BIT = 7;
  localparam int IDLE_BIT = 6;
  localparam int REQ_BIT  = 7;
  localparam int MODE_HI  = 6;
  localparam int MODE_LO  = 5;
  localparam int THR_HI   = 4;
  localparam int PDT_BIT  = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST  = 8'h20;
  localparam logic [7:0] THRES_RST = 8'hc7;
  localparam logic [7:0] SYNC_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 8;
  localparam int SYMBOL_NS    = 16000;
  localparam int MEAS_SYMBOLS = 8;
  localparam int RESULT_NS    = 140000;
  localparam int MEAS_CYC  = (MEAS_SYMBOLS * SYMBOL_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESULT_CYC = (RESULT_NS + CLK_NS - 1) / CLK_NS;

  localparam logic signed [9:0] SENS_FLOOR_DBM = -10'sd91;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OR      = 2'h0,
    MODE_ENERGY  = 2'h1,
    MODE_CARRIER = 2'h2,
    MODE_AND     = 2'h3
  } mode_type;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0001,
    ST_MEAS      = 4'b0010,
    ST_PROC      = 4'b0100,
    ST_WAIT_AUTO = 4'b1000
  } state_type;

endpackage

// File: core/cca_tmr_if.sv
// Handshake between the assessment control and its interval timers
`timescale 1ns/1ps
`default_nettype none
interface cca_tmr_if;
  logic start;
  logic running;
  logic meas_end;
  logic res_end;
  modport ctrl (output start, input running, meas_end, res_end);
  modport tmr  (input start, output running, meas_end, res_end);
endinterface
`default_nettype wire

// File: core/cca_timer.sv
// Interval timer: flags end of measurement and end of processing
`timescale 1ns/1ps
`default_nettype none
module cca_timer
  import cca_pkg::*;
#(
  parameter int CNT_W    = 16,
  parameter int MEAS_LEN = MEAS_CYC,
  parameter int RES_LEN  = RESULT_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control side
  cca_tmr_if.tmr    tp
);

  logic [CNT_W-1:0] cnt_r;
  logic             run_r;
  logic             meas_end_r;
  logic             res_end_r;

  // A new start restarts the count from one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (tp.start) begin
      cnt_r <= CNT_W'(1);
      run_r <= 1'b1;
    end else if (run_r) begin
      cnt_r <= cnt_r + CNT_W'(1);
      if (cnt_r == CNT_W'(RES_LEN)) begin
        run_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_end_r <= 1'b0;
      res_end_r  <= 1'b0;
    end else begin
      meas_end_r <= run_r && !tp.start && (cnt_r == CNT_W'(MEAS_LEN));
      res_end_r  <= run_r && !tp.start && (cnt_r == CNT_W'(RES_LEN));
    end
  end

  assign tp.running  = run_r;
  assign tp.meas_end = meas_end_r;
  assign tp.res_end  = res_end_r;

endmodule
`default_nettype wire

// File: tb/clear_channel_assessment_tb_top.sv
// Self-checking bench for the clear channel assessment block
`timescale 1ns/1ps
`default_nettype none
module clear_channel_assessment_tb_top;
  import cca_pkg::*;

  // --------------------------------------------------------------
  // Short counts keep the run brief; RC must exceed MC
  // --------------------------------------------------------------
  localparam int MC = 20;
  localparam int RC = 24;

  logic       clk;
  logic       rst_n;
  logic [5:0] reg_addr;
  logic       reg_wr_en;
  logic       reg_rd_en;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       basic_mode;
  logic       rx_listen;
  logic       rx_busy;
  logic       shr_detected;
  logic [4:0] rssi_value;
  logic       carrier_detect;
  logic [4:0] trx_state;
  logic       measure_done_event;
  logic       preamble_detect_disable;
  int         miscompares;
  int         tests_run;
  int         cycles = 0;
  int         t_req;
  logic [7:0] rv;
  logic       ebusy;
  logic       exp_idle;

  clear_channel_assessment #(.MEAS_CYCLES(MC), .RESULT_CYCLES(RC)) dut_u (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .basic_mode(basic_mode), .rx_listen(rx_listen), .rx_busy(rx_busy),
    .shr_detected(shr_detected), .rssi_value(rssi_value),
    .carrier_detect(carrier_detect), .trx_state(trx_state),
    .measure_done_event(measure_done_event),
    .preamble_detect_disable(preamble_detect_disable)
  );

  // --------------------------------------------------------------
  // Clock, cycle count and hang guard
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      end_sim;
    end
  end

  // --------------------------------------------------------------
  // Access and compare tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
    tests_run++;
    if (n < lo || n > hi) begin
      miscompares++;
      $display("Error at %0t: delay %h not in %h..%h", $time, n, lo, hi);
    end
  endtask

  // Each access first lets an edge pass, so a strobe never toggles
  // twice in one time step between back-to-back calls
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge clk);
    #1;
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge clk);
    #1;
    reg_rd_en = 1'b0;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask

  task automatic req(input logic [1:0] m);
    wr(CTRL_ADDR, {1'b1, m, 5'h0b});
    t_req = cycles;
  endtask

  // Delay counted from the request edge, not from the call
  task automatic wait_evt(input int lo, input int hi);
    while (measure_done_event !== 1'b1 && cycles - t_req <= hi) begin
      @(posedge clk);
      #1;
    end
    chk_rng(cycles - t_req, lo, hi);
  endtask

  task automatic stat(input logic d, input logic i);
    rd(STATUS_ADDR, rv);
    chk(rv, {d, i, 1'b0, trx_state});
  endtask

  task automatic frame;
    rx_busy = 1'b0;
    @(posedge clk);
    #1;
    rx_busy = 1'b1;
    shr_detected = 1'b1;
    @(posedge clk);
    #1;
    shr_detected = 1'b0;
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  function automatic logic en_over(input logic [4:0] r,
                                   input logic [4:0] f);
    return (r != 5'h00) && (3 * (int'(r) - 1) > 2 * int'(f));
  endfunction

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    miscompares = 0;
    tests_run = 0;
    rst_n = 1'b0;
    reg_addr = 6'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 8'h00;
    basic_mode = 1'b1;
    rx_listen = 1'b0;
    rx_busy = 1'b0;
    shr_detected = 1'b0;
    rssi_value = 5'h00;
    carrier_detect = 1'b0;
    trx_state = 5'h06;
    t_req = 0;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);

    // Reset values, unmapped place, read/write storage
    rd(CTRL_ADDR, rv);
    chk(rv, CTRL_RST);
    rd(THRES_ADDR, rv);
    chk(rv, THRES_RST);
    rd(SYNC_ADDR, rv);
    chk(rv, SYNC_RST);
    stat(1'b0, 1'b0);
    wr(6'h3f, 8'hff);
    rd(6'h3f, rv);
    chk(rv, 8'h00);
    wr(THRES_ADDR, 8'he3);
    rd(THRES_ADDR, rv);
    chk(rv, 8'he3);

    // Listening: every mode against every energy and carrier mix
    rx_listen = 1'b1;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        trx_state = 5'(m * 4 + k);
        rssi_value = k[0] ? 5'h04 : 5'h03;
        carrier_detect = k[1];
        ebusy = en_over(rssi_value, 5'h03);
        case (m)
          0: exp_idle = !(ebusy || carrier_detect);
          1: exp_idle = !ebusy;
          2: exp_idle = !carrier_detect;
          default: exp_idle = !(ebusy && carrier_detect);
        endcase
        req(m[1:0]);
        rd(CTRL_ADDR, rv);
        chk(rv, {1'b0, m[1:0], 5'h0b});
        stat(1'b0, 1'b0);
        wait_evt(RC, RC + 4);
        stat(1'b1, exp_idle);
      end
    end

    // Restart in mid-measurement: only the second one completes
    rssi_value = 5'h00;
    carrier_detect = 1'b0;
    req(2'h1);
    repeat (4) @(posedge clk);
    req(2'h1);
    wait_evt(RC, RC + 4);
    stat(1'b1, 1'b1);

    // Outside receive states, and in extended mode
    rx_listen = 1'b0;
    req(2'h2);
    wait_evt(0, 3);
    stat(1'b1, 1'b0);
    basic_mode = 1'b0;
    rx_listen = 1'b1;
    req(2'h0);
    wait_evt(0, 3);
    stat(1'b1, 1'b0);
    basic_mode = 1'b1;
    rx_listen = 1'b0;

    // Busy receive: request inside the automatic run
    frame;
    req(2'h1);
    wait_evt(0, 3);
    stat(1'b0, 1'b0);
    wait_evt(4, MC + 3);
    stat(1'b1, 1'b1);

    // New frame: carrier only answers at once
    frame;
    carrier_detect = 1'b1;
    req(2'h2);
    wait_evt(0, 3);
    stat(1'b1, 1'b0);
    carrier_detect = 1'b0;

    // After the run, and a second header in one frame starts none
    repeat (MC + 4) @(posedge clk);
    #1;
    shr_detected = 1'b1;
    @(posedge clk);
    #1;
    shr_detected = 1'b0;
    req(2'h3);
    wait_evt(0, 3);
    stat(1'b1, 1'b1);

    // Header detection held off: no automatic run to wait for
    wr(SYNC_ADDR, 8'h80);
    chk({7'h00, preamble_detect_disable}, 8'h01);
    rd(SYNC_ADDR, rv);
    chk(rv, 8'h80);
    frame;
    req(2'h1);
    wait_evt(0, 3);
    stat(1'b1, 1'b1);
    wr(SYNC_ADDR, 8'h00);
    chk({7'h00, preamble_detect_disable}, 8'h00);
    rx_busy = 1'b0;
    end_sim;
  end
endmodule
`default_nettype wire
